// ==== cdar_params.svh ====
// Offsets, field positions, reset values and timing counts for the channel two diagnostic bank
`ifndef CDAR_PARAMS_SVH
`define CDAR_PARAMS_SVH

`define CDAR_OFS_CONFIG         6'h18
`define CDAR_OFS_CURRENT        6'h19
`define CDAR_OFS_TEMPERATURE    6'h1a
`define CDAR_OFS_VOLTAGE        6'h1b

`define CDAR_CFG_RESET          16'hc002
`define CDAR_RES_RESET          16'h0000

`define CDAR_BIT_VSNS_DIS       15
`define CDAR_BIT_TSNS_DIS       14
`define CDAR_BIT_ISNS_DIS       13
`define CDAR_MSB_OL_THLD        12
`define CDAR_LSB_OL_THLD        11
`define CDAR_BIT_GAIN           10
`define CDAR_BIT_OL_ON_EN       9
`define CDAR_MSB_BLANK          8
`define CDAR_LSB_BLANK          7
`define CDAR_MSB_PULLUP         6
`define CDAR_LSB_PULLUP         5
`define CDAR_BIT_OL_OFF_EN      4
`define CDAR_BIT_SVBB_EN        3
`define CDAR_BIT_LATCH          2
`define CDAR_MSB_SLEW           1
`define CDAR_LSB_SLEW           0

`define CDAR_BIT_FRESH          10
`define CDAR_RESULT_W           10

// Blanking times in microseconds and the clock rate in kHz
`define CDAR_CLK_KHZ            20000
`define CDAR_BLANK0_US          400
`define CDAR_BLANK1_US          1000
`define CDAR_BLANK2_US          2000
`define CDAR_BLANK3_US          4000
`define CDAR_BLANK0_CYC         ((`CDAR_BLANK0_US * `CDAR_CLK_KHZ + 999) / 1000)
`define CDAR_BLANK1_CYC         ((`CDAR_BLANK1_US * `CDAR_CLK_KHZ + 999) / 1000)
`define CDAR_BLANK2_CYC         ((`CDAR_BLANK2_US * `CDAR_CLK_KHZ + 999) / 1000)
`define CDAR_BLANK3_CYC         ((`CDAR_BLANK3_US * `CDAR_CLK_KHZ + 999) / 1000)

`endif

// ==== cdar_pkg.sv ====
// Types shared by the channel two diagnostic bank
`default_nettype none
package cdar_pkg;
	typedef enum logic [1:0]
	{
		CDAR_SRC_CURRENT,
		CDAR_SRC_TEMPERATURE,
		CDAR_SRC_VOLTAGE
	} cdar_src_t;

	typedef enum logic [1:0]
	{
		CDAR_BLK_IDLE,
		CDAR_BLK_COUNT,
		CDAR_BLK_FAULT
	} cdar_blk_state_t;
endpackage
`default_nettype wire

// ==== cdar_result_slot.sv ====
// One sense result holder with its freshness flag
`timescale 1ns/1ps
`default_nettype none
`include "cdar_params.svh"
module cdar_result_slot
(
	input  wire logic                        clk_i,
	input  wire logic                        reset_n_i,
	input  wire logic                        enable_i,
	input  wire logic                        load_i,
	input  wire logic [`CDAR_RESULT_W-1:0]  data_i,
	input  wire logic                        read_i,
	output logic      [15:0]                 word_o
);
	logic [`CDAR_RESULT_W-1:0] value_r;
	logic                      fresh_r;

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			value_r <= '0;
		else if (load_i && enable_i)
			value_r <= data_i;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			fresh_r <= 1'b0;
		else if (load_i && enable_i)
			fresh_r <= 1'b1;
		else if (read_i)
			fresh_r <= 1'b0;
	end

	assign word_o = {5'h00, fresh_r, value_r};

	a_fresh_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		read_i && !(load_i && enable_i) |=> !fresh_r)
		else $error("fresh flag not cleared by read");
	a_fresh_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		load_i && enable_i |=> fresh_r && value_r == $past(data_i))
		else $error("fresh flag or value not loaded");
endmodule
`default_nettype wire

// ==== cdar_blank_timer.sv ====
// Persistence timer that turns a raw detector level into a registered fault
`timescale 1ns/1ps
`default_nettype none
`include "cdar_params.svh"
module cdar_blank_timer
(
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic [1:0]  sel_i,
	input  wire logic        cond_i,
	output logic             fault_o
);
	localparam int unsigned CW = 17;
	logic [CW-1:0]            cnt_r;
	logic [CW-1:0]            limit;
	cdar_pkg::cdar_blk_state_t state_r;

	function automatic logic [CW-1:0] blank_cycles(input logic [1:0] s);
		case (s)
			2'h0:    blank_cycles = CW'(`CDAR_BLANK0_CYC);
			2'h1:    blank_cycles = CW'(`CDAR_BLANK1_CYC);
			2'h2:    blank_cycles = CW'(`CDAR_BLANK2_CYC);
			default: blank_cycles = CW'(`CDAR_BLANK3_CYC);
		endcase
	endfunction

	assign limit = blank_cycles(sel_i);

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_r <= cdar_pkg::CDAR_BLK_IDLE;
			cnt_r   <= '0;
			fault_o <= 1'b0;
		end
		else if (!cond_i)
		begin
			state_r <= cdar_pkg::CDAR_BLK_IDLE;
			cnt_r   <= '0;
			fault_o <= 1'b0;
		end
		else
		begin
			case (state_r)
				cdar_pkg::CDAR_BLK_IDLE:
				begin
					state_r <= cdar_pkg::CDAR_BLK_COUNT;
					cnt_r   <= CW'(1);
				end
				cdar_pkg::CDAR_BLK_COUNT:
				begin
					if (cnt_r >= limit - CW'(1))
					begin
						state_r <= cdar_pkg::CDAR_BLK_FAULT;
						fault_o <= 1'b1;
					end
					cnt_r <= cnt_r + CW'(1);
				end
				cdar_pkg::CDAR_BLK_FAULT:
					fault_o <= 1'b1;
				default:
					state_r <= cdar_pkg::CDAR_BLK_IDLE;
			endcase
		end
	end

	a_blank_early: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$rose(fault_o) |-> $past(cond_i) && cnt_r >= limit - CW'(1))
		else $error("fault raised before blanking time");
endmodule
`default_nettype wire

// ==== cdar_regs.sv ====
// Channel two diagnostic configuration and sense result register bank
// Behaviour
// - Bit fifteen disables voltage sense, reset one
// - Bit fourteen disables temperature sense, reset one
// - Bit thirteen disables current sense, reset zero
// - Bit ten selects unity or 8x gain
// - Bit nine enables precise on-state open load
// - Bits eight-seven choose fault blanking time
// - Bits six-five choose open-load pull-up current
// - Bit four enables off-state open-load pull-up
// - Bit three enables supply-short pull-down
// - Bit two selects latch or auto retry
// - Bits one-zero choose slew, reset two
// - Bits twelve-eleven stored only, no effect
// - Current result holds latest 10-bit conversion
// - Bit ten flags conversion newer than read
// - Temperature result holds conversion and flag
// - Voltage result holds conversion and flag
`timescale 1ns/1ps
`default_nettype none
`include "cdar_params.svh"
module cdar_regs
(
	input  wire logic         CLK_SYS_I,
	input  wire logic         RESET_N_I,
	input  wire logic         REG_WR_I,
	input  wire logic         REG_RD_I,
	input  wire logic [5:0]   REG_ADDR_I,
	input  wire logic [15:0]  REG_WDATA_I,
	output logic      [15:0]  REG_RDATA_O,
	input  wire logic         CHANNEL_ON_I,
	input  wire logic         CHANNEL_FAULT_I,
	input  wire logic         LOAD_CURRENT_HIGH_I,
	input  wire logic         SWITCH_STATE_WRITE_I,
	input  wire logic         ADC_DONE_I,
	input  wire logic [1:0]   ADC_SRC_I,
	input  wire logic [9:0]   ADC_DATA_I,
	input  wire logic         OPENLOAD_RAW_I,
	input  wire logic         SUPPLY_SHORT_RAW_I,
	input  wire logic         SHUTDOWN_EVENT_I,
	input  wire logic         RETRY_READY_I,
	output logic              VOLTAGE_SENSE_EN_O,
	output logic              TEMPERATURE_SENSE_EN_O,
	output logic              CURRENT_SENSE_EN_O,
	output logic              CURRENT_SENSE_GAIN8_O,
	output logic              ONSTATE_OPENLOAD_EN_O,
	output logic      [1:0]   OPENLOAD_PULLUP_STRENGTH_O,
	output logic              OFFSTATE_PULLUP_EN_O,
	output logic              SUPPLY_SHORT_PULLDOWN_EN_O,
	output logic      [1:0]   OUTPUT_SLEW_SELECT_O,
	output logic              OPENLOAD_FAULT_O,
	output logic              SUPPLY_SHORT_FAULT_O,
	output logic              CHANNEL_ALLOWED_O
);
	logic [15:0] config_r;
	logic [15:0] cur_word;
	logic [15:0] tmp_word;
	logic [15:0] vlt_word;
	logic [15:0] rdata_nxt;
	logic        ol_fault;
	logic        sv_fault;
	logic        ol_cond;
	logic        latched_off_r;
	logic        guard_bad;
	logic [2:0]  rd_hit;
	logic [2:0]  src_hit;
	logic [2:0]  src_en;
	logic        sv_cond;
	logic [1:0]  raw_meta_r;
	logic [1:0]  raw_sync_r;

	function automatic logic addr_is(input logic [5:0] a, input logic [5:0] ofs);
		addr_is = (a == ofs);
	endfunction

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			config_r <= `CDAR_CFG_RESET;
		else if (REG_WR_I && addr_is(REG_ADDR_I, `CDAR_OFS_CONFIG))
			config_r <= REG_WDATA_I;
	end

	// precise open load needs quiet channel
	// pull-up only when off, no fault
	// pull-down only when off, no fault
	assign guard_bad = CHANNEL_ON_I || CHANNEL_FAULT_I;

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			VOLTAGE_SENSE_EN_O         <= 1'b0;
			TEMPERATURE_SENSE_EN_O     <= 1'b0;
			CURRENT_SENSE_EN_O         <= 1'b1;
			CURRENT_SENSE_GAIN8_O      <= 1'b0;
			ONSTATE_OPENLOAD_EN_O      <= 1'b0;
			OPENLOAD_PULLUP_STRENGTH_O <= 2'h0;
			OFFSTATE_PULLUP_EN_O       <= 1'b0;
			SUPPLY_SHORT_PULLDOWN_EN_O <= 1'b0;
			OUTPUT_SLEW_SELECT_O       <= 2'h2;
		end
		else
		begin
			VOLTAGE_SENSE_EN_O         <= !config_r[`CDAR_BIT_VSNS_DIS];
			TEMPERATURE_SENSE_EN_O     <= !config_r[`CDAR_BIT_TSNS_DIS];
			CURRENT_SENSE_EN_O         <= !config_r[`CDAR_BIT_ISNS_DIS];
			CURRENT_SENSE_GAIN8_O      <= config_r[`CDAR_BIT_GAIN];
			ONSTATE_OPENLOAD_EN_O      <= config_r[`CDAR_BIT_OL_ON_EN]
				&& !CHANNEL_FAULT_I && !LOAD_CURRENT_HIGH_I;
			OPENLOAD_PULLUP_STRENGTH_O <= config_r[`CDAR_MSB_PULLUP:`CDAR_LSB_PULLUP];
			OFFSTATE_PULLUP_EN_O       <= config_r[`CDAR_BIT_OL_OFF_EN] && !guard_bad;
			SUPPLY_SHORT_PULLDOWN_EN_O <= config_r[`CDAR_BIT_SVBB_EN] && !guard_bad;
			OUTPUT_SLEW_SELECT_O       <= config_r[`CDAR_MSB_SLEW:`CDAR_LSB_SLEW];
		end
	end

	// Comparator levels are asynchronous, two flops first
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			raw_meta_r <= 2'h0;
			raw_sync_r <= 2'h0;
		end
		else
		begin
			raw_meta_r <= {SUPPLY_SHORT_RAW_I, OPENLOAD_RAW_I};
			raw_sync_r <= raw_meta_r;
		end
	end

	assign ol_cond = raw_sync_r[0] && (OFFSTATE_PULLUP_EN_O || ONSTATE_OPENLOAD_EN_O);
	assign sv_cond = raw_sync_r[1] && SUPPLY_SHORT_PULLDOWN_EN_O;

	cdar_blank_timer u_ol_blank
	(
		.clk_i     (CLK_SYS_I),
		.reset_n_i (RESET_N_I),
		.sel_i     (config_r[`CDAR_MSB_BLANK:`CDAR_LSB_BLANK]),
		.cond_i    (ol_cond),
		.fault_o   (ol_fault)
	);

	cdar_blank_timer u_sv_blank
	(
		.clk_i     (CLK_SYS_I),
		.reset_n_i (RESET_N_I),
		.sel_i     (config_r[`CDAR_MSB_BLANK:`CDAR_LSB_BLANK]),
		.cond_i    (sv_cond),
		.fault_o   (sv_fault)
	);

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			OPENLOAD_FAULT_O     <= 1'b0;
			SUPPLY_SHORT_FAULT_O <= 1'b0;
		end
		else
		begin
			OPENLOAD_FAULT_O     <= ol_fault;
			SUPPLY_SHORT_FAULT_O <= sv_fault;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			latched_off_r <= 1'b0;
		else if (SHUTDOWN_EVENT_I)
			latched_off_r <= 1'b1;
		else if (config_r[`CDAR_BIT_LATCH] ? SWITCH_STATE_WRITE_I : RETRY_READY_I)
			latched_off_r <= 1'b0;
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			CHANNEL_ALLOWED_O <= 1'b1;
		else
			CHANNEL_ALLOWED_O <= !latched_off_r && !SHUTDOWN_EVENT_I;
	end

	assign rd_hit[0] = REG_RD_I && addr_is(REG_ADDR_I, `CDAR_OFS_CURRENT);
	assign rd_hit[1] = REG_RD_I && addr_is(REG_ADDR_I, `CDAR_OFS_TEMPERATURE);
	assign rd_hit[2] = REG_RD_I && addr_is(REG_ADDR_I, `CDAR_OFS_VOLTAGE);
	assign src_en    = {VOLTAGE_SENSE_EN_O, TEMPERATURE_SENSE_EN_O, CURRENT_SENSE_EN_O};

	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_src
			assign src_hit[g] = ADC_DONE_I && (ADC_SRC_I == 2'(g));
		end
	endgenerate

	cdar_result_slot u_cur
	(
		.clk_i     (CLK_SYS_I),
		.reset_n_i (RESET_N_I),
		.enable_i  (src_en[0]),
		.load_i    (src_hit[0]),
		.data_i    (ADC_DATA_I),
		.read_i    (rd_hit[0]),
		.word_o    (cur_word)
	);

	cdar_result_slot u_tmp
	(
		.clk_i     (CLK_SYS_I),
		.reset_n_i (RESET_N_I),
		.enable_i  (src_en[1]),
		.load_i    (src_hit[1]),
		.data_i    (ADC_DATA_I),
		.read_i    (rd_hit[1]),
		.word_o    (tmp_word)
	);

	cdar_result_slot u_vlt
	(
		.clk_i     (CLK_SYS_I),
		.reset_n_i (RESET_N_I),
		.enable_i  (src_en[2]),
		.load_i    (src_hit[2]),
		.data_i    (ADC_DATA_I),
		.read_i    (rd_hit[2]),
		.word_o    (vlt_word)
	);

	always_comb
	begin
		case (REG_ADDR_I)
			`CDAR_OFS_CONFIG:      rdata_nxt = config_r;
			`CDAR_OFS_CURRENT:     rdata_nxt = cur_word;
			`CDAR_OFS_TEMPERATURE: rdata_nxt = tmp_word;
			`CDAR_OFS_VOLTAGE:     rdata_nxt = vlt_word;
			default:               rdata_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			REG_RDATA_O <= 16'h0000;
		else if (REG_RD_I)
			REG_RDATA_O <= rdata_nxt;
	end

	a_vsns_gate: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		##1 VOLTAGE_SENSE_EN_O == !$past(config_r[`CDAR_BIT_VSNS_DIS]))
		else $error("voltage sense enable wrong");
	a_tsns_gate: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		##1 TEMPERATURE_SENSE_EN_O == !$past(config_r[`CDAR_BIT_TSNS_DIS]))
		else $error("temperature sense enable wrong");
	a_isns_block: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		!CURRENT_SENSE_EN_O && !rd_hit[0] |=> $stable(cur_word))
		else $error("current result changed while disabled");
	a_gain_sel: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		$past(REG_WR_I && REG_ADDR_I == `CDAR_OFS_CONFIG, 2) |->
		CURRENT_SENSE_GAIN8_O == $past(REG_WDATA_I[`CDAR_BIT_GAIN], 2))
		else $error("gain select not applied");
	// precise open load blocked by fault
	a_olon_guard: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		$past(CHANNEL_FAULT_I || LOAD_CURRENT_HIGH_I) |-> !ONSTATE_OPENLOAD_EN_O)
		else $error("precise open load enabled under fault");
	a_pullup_str: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		##1 OPENLOAD_PULLUP_STRENGTH_O == $past(config_r[6:5]))
		else $error("pull-up strength wrong");
	a_pullup_off: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		$past(CHANNEL_ON_I) |-> !OFFSTATE_PULLUP_EN_O)
		else $error("pull-up enabled while channel on");
	a_pulldn_off: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		$past(CHANNEL_FAULT_I) |-> !SUPPLY_SHORT_PULLDOWN_EN_O)
		else $error("pull-down enabled under fault");
	a_latch_hold: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		latched_off_r && config_r[`CDAR_BIT_LATCH] && !SWITCH_STATE_WRITE_I
		|=> latched_off_r)
		else $error("latched channel released without write");
	a_slew_sel: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		##1 OUTPUT_SLEW_SELECT_O == $past(config_r[1:0]))
		else $error("slew select wrong");
	a_rsvd_zero: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		$past(REG_RD_I && REG_ADDR_I != `CDAR_OFS_CONFIG) |-> REG_RDATA_O[15:11] == 5'h00)
		else $error("reserved result bits nonzero");
	// precise open load follows bit nine
	a_olon_set: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		$past(config_r[`CDAR_BIT_OL_ON_EN] && !CHANNEL_FAULT_I && !LOAD_CURRENT_HIGH_I)
		|-> ONSTATE_OPENLOAD_EN_O)
		else $error("precise open load not enabled");
	a_pullup_flt: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		$past(CHANNEL_FAULT_I) |-> !OFFSTATE_PULLUP_EN_O)
		else $error("pull-up enabled under fault");
	a_pulldn_on: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		$past(CHANNEL_ON_I) |-> !SUPPLY_SHORT_PULLDOWN_EN_O)
		else $error("pull-down enabled while channel on");
	a_ol_persist: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		OPENLOAD_FAULT_O |-> $past(ol_cond, 2))
		else $error("open-load fault without condition");
	a_sv_persist: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		SUPPLY_SHORT_FAULT_O |-> $past(sv_cond, 2))
		else $error("supply-short fault without condition");
	a_shut_off: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		SHUTDOWN_EVENT_I |=> !CHANNEL_ALLOWED_O)
		else $error("channel allowed after shutdown");
	a_retry_rel: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		latched_off_r && !config_r[`CDAR_BIT_LATCH] && RETRY_READY_I && !SHUTDOWN_EVENT_I
		|=> !latched_off_r)
		else $error("retry did not release channel");
	a_cfg_rdback: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		$past(REG_RD_I && REG_ADDR_I == `CDAR_OFS_CONFIG) |-> REG_RDATA_O == $past(config_r))
		else $error("config read data wrong");
	a_cur_read: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		$past(rd_hit[0]) |-> REG_RDATA_O == $past(cur_word))
		else $error("current result read wrong");
	a_tmp_read: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		$past(rd_hit[1]) |-> REG_RDATA_O == $past(tmp_word))
		else $error("temperature result read wrong");
	a_vlt_read: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		$past(rd_hit[2]) |-> REG_RDATA_O == $past(vlt_word))
		else $error("voltage result read wrong");
endmodule
`default_nettype wire

// ==== cdar_host.sv ====
// Host model that reaches the diagnostic bank over its register strobes
`timescale 1ns/1ps
`default_nettype none
module cdar_host
(
	input  wire logic         clk_i,
	input  wire logic         chan_on_i,
	input  wire logic         fault_i,
	input  wire logic         cur_high_i,
	input  wire logic [15:0]  rdata_i,
	output logic              wr_o,
	output logic              rd_o,
	output logic      [5:0]   addr_o,
	output logic      [15:0]  wdata_o
);
	initial
	begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 6'h3f;
		wdata_o = 16'h0000;
	end

	task automatic write(input logic [5:0] a, input logic [15:0] d);
		logic [15:0] v;
		v = d;
		if (a == 6'h18 && (fault_i || cur_high_i))
			v[9] = 1'b0;
		if (a == 6'h18 && (fault_i || chan_on_i))
			v[4:3] = 2'b00;
		@(negedge clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= v;
		@(negedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~v;
	endtask

	task automatic read(input logic [5:0] a, output logic [15:0] d);
		@(negedge clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(negedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		d = rdata_i;
	endtask
endmodule
`default_nettype wire

// ==== channel_diag_adc_regs_tb.sv ====
// Self-checking bench for the channel two diagnostic register bank
`timescale 1ns/1ps
`default_nettype none
module channel_diag_adc_regs_tb;
	logic         clk, rst_n, wr, rd, on, flt, hi, sww, done, olr, ssr, shut, rty;
	logic [5:0]   addr;
	logic [15:0]  wdata, rdata, rv;
	logic [1:0]   src, pus, slew;
	logic [9:0]   dat;
	logic         ven, ten, ien, g8, onol, opu, spd, olf, ssf, alw;
	int           n_mismatch, n_tests;

	cdar_host i_host (.clk_i(clk), .chan_on_i(on), .fault_i(flt), .cur_high_i(hi),
		.rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));

	cdar_regs i_dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .CHANNEL_ON_I(on),
		.CHANNEL_FAULT_I(flt), .LOAD_CURRENT_HIGH_I(hi), .SWITCH_STATE_WRITE_I(sww),
		.ADC_DONE_I(done), .ADC_SRC_I(src), .ADC_DATA_I(dat), .OPENLOAD_RAW_I(olr),
		.SUPPLY_SHORT_RAW_I(ssr), .SHUTDOWN_EVENT_I(shut), .RETRY_READY_I(rty),
		.VOLTAGE_SENSE_EN_O(ven), .TEMPERATURE_SENSE_EN_O(ten), .CURRENT_SENSE_EN_O(ien),
		.CURRENT_SENSE_GAIN8_O(g8), .ONSTATE_OPENLOAD_EN_O(onol),
		.OPENLOAD_PULLUP_STRENGTH_O(pus), .OFFSTATE_PULLUP_EN_O(opu),
		.SUPPLY_SHORT_PULLDOWN_EN_O(spd), .OUTPUT_SLEW_SELECT_O(slew),
		.OPENLOAD_FAULT_O(olf), .SUPPLY_SHORT_FAULT_O(ssf), .CHANNEL_ALLOWED_O(alw));

	always #25 clk = ~clk;

	task automatic end_sim;
		if (n_mismatch == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task automatic chk_bit(input logic g, input logic e, input string m);
		chk({15'h0, g}, {15'h0, e}, m);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic rdc(input logic [5:0] a, input logic [15:0] e, input string m);
		i_host.read(a, rv);
		chk(rv, e, m);
	endtask

	task automatic wrc(input logic [5:0] a, input logic [15:0] d);
		i_host.write(a, d);
		cyc(2);
	endtask

	task automatic conv(input logic [1:0] s, input logic [9:0] d);
		@(negedge clk);
		done = 1'b1;
		src = s;
		dat = d;
		@(negedge clk);
		done = 1'b0;
		dat = ~d;
	endtask

	task automatic pulse(input int w);
		if (w == 0)
			shut = 1'b1;
		else if (w == 1)
			rty = 1'b1;
		else
			sww = 1'b1;
		cyc(1);
		shut = 1'b0;
		rty = 1'b0;
		sww = 1'b0;
		cyc(2);
	endtask

	task automatic t_reset;
		rdc(6'h18, 16'hc002, "cfg rst");
		chk_bit(ven, 1'b0, "ven rst");
		chk_bit(ten, 1'b0, "ten rst");
		chk_bit(ien, 1'b1, "ien rst");
		chk_bit(alw, 1'b1, "alw rst");
		chk({14'h0, slew}, 16'h0002, "slew rst");
		rdc(6'h19, 16'h0000, "cur rst");
		rdc(6'h1a, 16'h0000, "tmp rst");
		rdc(6'h1b, 16'h0000, "vlt rst");
	endtask

	task automatic t_adc;
		conv(2'd0, 10'h2a5);
		rdc(6'h19, 16'h06a5, "cur fresh");
		rdc(6'h19, 16'h02a5, "cur clr");
		conv(2'd1, 10'h155);
		conv(2'd2, 10'h3ff);
		rdc(6'h1a, 16'h0000, "tmp off");
		rdc(6'h1b, 16'h0000, "vlt off");
		wrc(6'h18, 16'h2002);
		conv(2'd0, 10'h001);
		rdc(6'h19, 16'h02a5, "cur off");
		conv(2'd1, 10'h155);
		conv(2'd2, 10'h3ff);
		rdc(6'h1a, 16'h0555, "tmp new");
		rdc(6'h1b, 16'h07ff, "vlt new");
		conv(2'd2, 10'h200);
		rdc(6'h1b, 16'h0600, "vlt reload");
		conv(2'd3, 10'h0aa);
		wrc(6'h1a, 16'hffff);
		rdc(6'h1a, 16'h0155, "tmp ro");
		rdc(6'h1b, 16'h0200, "vlt src3");
		wrc(6'h3f, 16'hffff);
		rdc(6'h3f, 16'h0000, "unmapped");
	endtask

	task automatic t_config;
		wrc(6'h18, 16'h3fff);
		rdc(6'h18, 16'h3fff, "cfg rb");
		chk_bit(ven, 1'b1, "ven");
		chk_bit(ten, 1'b1, "ten");
		chk_bit(ien, 1'b0, "ien");
		chk_bit(g8, 1'b1, "gain");
		chk_bit(onol, 1'b1, "onol");
		chk_bit(opu, 1'b1, "pullup");
		chk_bit(spd, 1'b1, "pulldown");
		on = 1'b1;
		cyc(3);
		chk_bit(opu, 1'b0, "pullup on");
		chk_bit(spd, 1'b0, "pulldown on");
		on = 1'b0;
		hi = 1'b1;
		cyc(3);
		chk_bit(onol, 1'b0, "onol hi");
		hi = 1'b0;
		flt = 1'b1;
		cyc(3);
		chk_bit(onol, 1'b0, "onol flt");
		chk_bit(spd, 1'b0, "pulldown flt");
		chk_bit(opu, 1'b0, "pullup flt");
		flt = 1'b0;
		for (int k = 0; k < 4; k++)
		begin
			wrc(6'h18, {9'h000, k[1:0], 3'h0, k[1:0]});
			chk_bit(g8, 1'b0, "gain off");
			chk({14'h0, pus}, {14'h0, k[1:0]}, "pu str");
			chk({14'h0, slew}, {14'h0, k[1:0]}, "slew");
		end
	endtask

	task automatic t_blank(input logic ss, input logic [1:0] code, input int n);
		int cnt;
		cnt = 0;
		wrc(6'h18, {7'h0c, code, 2'b00, 5'h1a});
		olr = ~ss;
		ssr = ss;
		while ((ss ? ssf : olf) !== 1'b1 && cnt < n + 50)
		begin
			cyc(1);
			cnt++;
		end
		chk_bit(cnt >= n && cnt <= n + 4, 1'b1, "blank time");
		if (cnt >= n + 50)
			end_sim;
		chk_bit(ss ? olf : ssf, 1'b0, "other fault");
		olr = 1'b0;
		ssr = 1'b0;
		cyc(4);
		chk_bit(ss ? ssf : olf, 1'b0, "fault drop");
	endtask

	task automatic t_blank_long;
		wrc(6'h18, 16'h019a);
		olr = 1'b1;
		cyc(8100);
		chk_bit(olf, 1'b0, "blank long");
		olr = 1'b0;
		cyc(4);
	endtask

	task automatic t_latch;
		wrc(6'h18, 16'h0006);
		pulse(0);
		chk_bit(alw, 1'b0, "latched off");
		pulse(1);
		chk_bit(alw, 1'b0, "latch holds");
		pulse(2);
		chk_bit(alw, 1'b1, "latch rel");
		wrc(6'h18, 16'h0002);
		pulse(0);
		chk_bit(alw, 1'b0, "retry off");
		pulse(1);
		chk_bit(alw, 1'b1, "retry rel");
	endtask

	initial
	begin
		{clk, rst_n, on, flt, hi, sww, done, olr, ssr, shut, rty} = '0;
		src = 2'd0;
		dat = 10'h000;
		n_mismatch = 0;
		n_tests = 0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		t_reset;
		t_adc;
		t_config;
		t_blank(1'b0, 2'd0, 8000);
		t_blank(1'b1, 2'd1, 20000);
		t_blank(1'b0, 2'd2, 40000);
		t_blank_long;
		t_latch;
		end_sim;
	end
endmodule
`default_nettype wire
